// *** logic/hrp_pkg.sv ***
package hrp_pkg;

  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 16;
  localparam int BYTE_W      = 8;
  localparam int CTRL_AW     = 4;
  localparam int CTRL_DEPTH  = 16;

  localparam logic [6:0] OFF_CFG     = 7'h02;
  localparam logic [6:0] OFF_STAT_EN = 7'h10;
  localparam logic [6:0] OFF_STAT_ST = 7'h11;
  localparam logic [6:0] OFF_DL_EN   = 7'h12;
  localparam logic [6:0] OFF_DL_ST   = 7'h13;
  localparam logic [6:0] OFF_EVT_CNT = 7'h14;
  localparam logic [6:0] OFF_PIN_ST  = 7'h15;

  localparam int   CFG_INIT_BIT = 9;
  localparam logic CFG_INIT_RST = 1'b1;

  // synchronised pin vector layout
  localparam int         PIN_W         = 4;
  localparam int         PIN_WIDTH_SEL = 0;
  localparam int         PIN_RX_CLK    = 1;
  localparam int         PIN_STAT_LINE = 2;
  localparam int         PIN_DL_LINE   = 3;
  localparam logic [3:0] PIN_RST       = 4'hc;

  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [1:0]  BE_LOW    = 2'h1;
  localparam logic [1:0]  BE_HIGH   = 2'h2;
  localparam logic [1:0]  BE_WORD   = 2'h3;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'b00,
    RD_FETCH = 2'b01,
    RD_DRIVE = 2'b10
  } hrp_rd_state_t;

  typedef struct packed {
    logic        byte_mode;
    logic        high_lane;
    logic [6:0]  addr;
  } hrp_req_t;

  typedef struct packed {
    logic [1:0]  be;
    logic [15:0] data;
  } hrp_wr_t;

  // lane select rides on the top data bit in byte mode
  function automatic hrp_wr_t write_lanes(input logic byte_mode, input logic [15:0] din);
    hrp_wr_t w;
    if (!byte_mode) begin
      w.be   = BE_WORD;
      w.data = din;
    end else if (din[15]) begin
      w.be   = BE_HIGH;
      w.data = {din[7:0], din[7:0]};
    end else begin
      w.be   = BE_LOW;
      w.data = {din[7:0], din[7:0]};
    end
    return w;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input hrp_wr_t w);
    return {w.be[1] ? w.data[15:8] : old[15:8], w.be[0] ? w.data[7:0] : old[7:0]};
  endfunction

  function automatic logic is_ctrl(input logic [6:0] a);
    return a[6:4] == 3'h0;
  endfunction

endpackage

// *** logic/hrp_regmem.sv ***
`timescale 1ns/1ns
// control word store; no reset so contents survive a hardware reset
module hrp_regmem #(
  parameter int AW    = 4,
  parameter int DEPTH = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          clk_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [1:0]    wr_be,
  input  wire logic [15:0]   wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output      logic [15:0]   rd_data
);

  logic [15:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      if (wr_be[0]) begin
        mem[wr_addr][7:0] <= wr_data[7:0];
      end
      if (wr_be[1]) begin
        mem[wr_addr][15:8] <= wr_data[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // hrp_regmem

// *** logic/hrp_host_port.sv ***
`timescale 1ns/1ns
module hrp_host_port #(
  parameter int          N_STAT  = 8,
  parameter int          N_HDLC  = 3,
  parameter logic [7:0]  RX_MASK = 8'h0f
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              bus_width_select,
  input  wire logic              address_strobe_n,
  input  wire logic [6:0]        addr,
  input  wire logic              rd_req,
  input  wire logic              wr_req,
  input  wire logic [15:0]       data_in,
  output      logic [15:0]       data_out,
  output      logic              data_oe_n,
  output      logic              bus_busy,
  input  wire logic              rx_clk_active,
  input  wire logic [N_STAT-1:0] stat_event,
  input  wire logic              count_tick,
  input  wire logic              far_end_alarm_channel_event,
  input  wire logic [N_HDLC-1:0] hdlc_event,
  input  wire logic              status_irq_n_i,
  output      logic              status_irq_n_o,
  output      logic              status_irq_oe_n,
  input  wire logic              datalink_irq_n_i,
  output      logic              datalink_irq_n_o,
  output      logic              datalink_irq_oe_n
);

  localparam int NS = N_STAT + 1;
  localparam int ND = N_HDLC + 1;

  hrp_pkg::hrp_rd_state_t state;
  hrp_pkg::hrp_req_t      req;
  hrp_pkg::hrp_wr_t       wr;

  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  sync3;
  logic [3:0]  pin_q;
  logic [3:0]  pin_agree;
  logic        byte_mode;
  logic        rx_clk_ok;
  logic [6:0]  addr_q;
  logic [6:0]  eff_addr;
  logic        wr_take;
  logic        rd_take;
  logic        mem_wr;
  logic [15:0] mem_rdata;
  logic [15:0] cfg;
  logic [15:0] stat_en;
  logic [15:0] dl_en;
  logic [NS-1:0] stat_st;
  logic [ND-1:0] dl_st;
  logic [NS-1:0] stat_set;
  logic [ND-1:0] dl_set;
  logic [NS-1:0] stat_clr;
  logic [ND-1:0] dl_clr;
  logic [15:0] evt_cnt;
  logic        cnt_ovf;
  logic [15:0] rd_word;
  logic [7:0]  hold;
  logic        clr_ok;
  logic        stat_act;
  logic        dl_act;
  logic        hit_cfg;
  logic        hit_stat_en;
  logic        hit_dl_en;

  // pins pass three flops; a change counts once the last two agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1 <= hrp_pkg::PIN_RST;
      sync2 <= hrp_pkg::PIN_RST;
      sync3 <= hrp_pkg::PIN_RST;
    end else if (clk_en) begin
      sync1 <= {datalink_irq_n_i, status_irq_n_i, rx_clk_active, bus_width_select};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a bit moves only where the last two stages agree, so one glitch is ignored
  assign pin_agree = sync2 ~^ sync3;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_q <= hrp_pkg::PIN_RST;
    end else if (clk_en) begin
      pin_q <= (pin_agree & sync3) | (~pin_agree & pin_q);
    end
  end

  // strap picks byte or word access
  assign byte_mode = pin_q[hrp_pkg::PIN_WIDTH_SEL];
  assign rx_clk_ok = pin_q[hrp_pkg::PIN_RX_CLK];

  // address latched while strobe is low
  always_ff @(posedge ref_clk) begin
    if (clk_en && !address_strobe_n) begin
      addr_q <= addr;
    end
  end

  // strobe high: the address latched at the last low strobe is reused
  assign eff_addr = address_strobe_n ? addr_q : addr;

  // write decode, shared by the register processes
  assign hit_cfg     = (eff_addr == hrp_pkg::OFF_CFG);
  assign hit_stat_en = (eff_addr == hrp_pkg::OFF_STAT_EN);
  assign hit_dl_en   = (eff_addr == hrp_pkg::OFF_DL_EN);

  // requests taken on the clock edge, one at a time
  // a request while busy is dropped without notice; the host paces itself
  assign wr_take  = wr_req && (state == hrp_pkg::RD_IDLE) && !sys_rst;
  assign rd_take  = rd_req && !wr_req && (state == hrp_pkg::RD_IDLE) && !sys_rst;
  assign bus_busy = (state != hrp_pkg::RD_IDLE);
  assign wr       = hrp_pkg::write_lanes(byte_mode, data_in);

  // only decoded control words are written
  // cfg sits in its own flops so its init bit can follow reset
  assign mem_wr = wr_take && hrp_pkg::is_ctrl(eff_addr) && !hit_cfg;

  // read port only enabled on a taken read, so its output holds in between
  hrp_regmem #(
    .AW    (hrp_pkg::CTRL_AW),
    .DEPTH (hrp_pkg::CTRL_DEPTH)
  ) u_regmem (
    .ref_clk (ref_clk),
    .clk_en  (clk_en),
    .wr_en   (mem_wr),
    .wr_addr (eff_addr[hrp_pkg::CTRL_AW-1:0]),
    .wr_be   (wr.be),
    .wr_data (wr.data),
    .rd_en   (rd_take),
    .rd_addr (eff_addr[hrp_pkg::CTRL_AW-1:0]),
    .rd_data (mem_rdata)
  );

  // reset only re-arms the init bit; the rest of the word is kept
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg[hrp_pkg::CFG_INIT_BIT] <= hrp_pkg::CFG_INIT_RST;
    end else if (clk_en && wr_take && hit_cfg) begin
      // byte lanes merge into the word
      cfg <= hrp_pkg::merge(cfg, wr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_take && hit_stat_en) begin
      stat_en <= hrp_pkg::merge(stat_en, wr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_take && hit_dl_en) begin
      dl_en <= hrp_pkg::merge(dl_en, wr);
    end
  end

  // overflow of the event counter is an interrupt source
  assign cnt_ovf = count_tick && (evt_cnt == hrp_pkg::CNT_MAX);

  // the counter wraps and a read never clears it; overflow leaves a status bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      evt_cnt <= hrp_pkg::WORD_ZERO;
    end else if (clk_en && count_tick) begin
      evt_cnt <= evt_cnt + 16'h0001;
    end
  end

  // receiver sources cannot fire while the receive clock is down
  assign stat_set = {cnt_ovf, stat_event & ~(RX_MASK & {N_STAT{~rx_clk_ok}})};
  // alarm channel in bit 0, hdlc events above it
  assign dl_set   = {hdlc_event, far_end_alarm_channel_event};

  // reading a status word clears it; a high-byte read uses the latch instead
  assign clr_ok   = (state == hrp_pkg::RD_FETCH) && !(req.byte_mode && req.high_lane);
  assign stat_clr = (clr_ok && req.addr == hrp_pkg::OFF_STAT_ST) ? stat_st : '0;
  assign dl_clr   = (clr_ok && req.addr == hrp_pkg::OFF_DL_ST) ? dl_st : '0;

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_st <= '0;
    end else if (clk_en) begin
      stat_st <= (stat_st & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dl_st <= '0;
    end else if (clk_en) begin
      dl_st <= (dl_st & ~dl_clr) | dl_set;
    end
  end

  // read map: control words read back, status and counter read only
  always_comb begin
    rd_word = hrp_pkg::WORD_ZERO;
    if (hrp_pkg::is_ctrl(req.addr)) begin
      rd_word = (req.addr == hrp_pkg::OFF_CFG) ? cfg : mem_rdata;
    end else begin
      case (req.addr)
        hrp_pkg::OFF_STAT_EN: rd_word = stat_en;
        hrp_pkg::OFF_STAT_ST: rd_word = 16'(stat_st);
        hrp_pkg::OFF_DL_EN:   rd_word = dl_en;
        hrp_pkg::OFF_DL_ST:   rd_word = 16'(dl_st);
        hrp_pkg::OFF_EVT_CNT: rd_word = evt_cnt;
        hrp_pkg::OFF_PIN_ST:  rd_word = 16'(pin_q);
        default:              rd_word = hrp_pkg::WORD_ZERO;
      endcase
    end
  end

  // read: fetch one cycle, drive the next
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= hrp_pkg::RD_IDLE;
    end else if (clk_en) begin
      case (state)
        hrp_pkg::RD_IDLE: begin
          if (rd_take) begin
            state <= hrp_pkg::RD_FETCH;
          end
        end
        hrp_pkg::RD_FETCH: state <= hrp_pkg::RD_DRIVE;
        hrp_pkg::RD_DRIVE: state <= hrp_pkg::RD_IDLE;
        default:           state <= hrp_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req <= '0;
    end else if (clk_en && rd_take) begin
      req.byte_mode <= byte_mode;
      req.high_lane <= data_in[15];
      req.addr      <= eff_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_out <= hrp_pkg::WORD_ZERO;
    end else if (clk_en && state == hrp_pkg::RD_FETCH) begin
      if (!req.byte_mode) begin
        data_out <= rd_word;
      end else if (req.high_lane) begin
        // high byte comes from the latch of the last low read
        data_out <= {hrp_pkg::BYTE_ZERO, hold};
      end else begin
        data_out <= {hrp_pkg::BYTE_ZERO, rd_word[7:0]};
      end
    end
  end

  // high byte latched on every low-lane read, for the next read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hold <= hrp_pkg::BYTE_ZERO;
    end else if (clk_en && state == hrp_pkg::RD_FETCH && req.byte_mode && !req.high_lane) begin
      hold <= rd_word[15:8];
    end
  end

  // data bus driven only in the drive cycle of a read
  assign data_oe_n = (state != hrp_pkg::RD_DRIVE);

  // held while any enabled status bit is set, gated until init bit clears
  assign stat_act = (|(16'(stat_st) & stat_en)) && !cfg[hrp_pkg::CFG_INIT_BIT];
  assign dl_act   = (|(16'(dl_st) & dl_en)) && !cfg[hrp_pkg::CFG_INIT_BIT];

  // open drain: pull low when active, release otherwise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_irq_oe_n <= 1'b1;
    end else if (clk_en) begin
      status_irq_oe_n <= !stat_act;
    end
  end

  // link interrupt has its own enable group
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      datalink_irq_oe_n <= 1'b1;
    end else if (clk_en) begin
      datalink_irq_oe_n <= !dl_act;
    end
  end

  assign status_irq_n_o   = 1'b0;
  assign datalink_irq_n_o = 1'b0;

endmodule // hrp_host_port

// *** testbench/hrp_host_port_properties.sv ***
`timescale 1ns/1ns
module hrp_host_port_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic bus_busy,
  input wire logic data_oe_n,
  input wire logic status_irq_n_o,
  input wire logic status_irq_oe_n,
  input wire logic datalink_irq_n_o
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_rd_lat;
    clk_en && !bus_busy && rd_req && !wr_req |=> bus_busy ##1 (bus_busy && !data_oe_n);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer off time");
  property p_oe_one;
    !data_oe_n |=> data_oe_n;
  endproperty
  a_oe_one: assert property (p_oe_one) else $error("read drive too long");
  property p_wr_nodrv;
    clk_en && !bus_busy && wr_req |=> data_oe_n ##1 data_oe_n;
  endproperty
  a_wr_nodrv: assert property (p_wr_nodrv) else $error("bus driven on write");
  property p_busy;
    !data_oe_n |-> bus_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("drive outside read");
  property p_st_od;
    status_irq_n_o == 1'b0;
  endproperty
  a_st_od: assert property (p_st_od) else $error("status pin not open drain");
  property p_dl_od;
    datalink_irq_n_o == 1'b0;
  endproperty
  a_dl_od: assert property (p_dl_od) else $error("link pin not open drain");
  property p_rst;
    $fell(sys_rst) |-> data_oe_n && !bus_busy && status_irq_oe_n;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold;
    (!status_irq_oe_n && !rd_req && !wr_req && !bus_busy) [*4] |=> !status_irq_oe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped");
endmodule // hrp_host_port_properties

bind hrp_host_port hrp_host_port_properties u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .rd_req(rd_req),
  .wr_req(wr_req), .bus_busy(bus_busy), .data_oe_n(data_oe_n),
  .status_irq_n_o(status_irq_n_o), .status_irq_oe_n(status_irq_oe_n),
  .datalink_irq_n_o(datalink_irq_n_o)
);

// *** testbench/hrp_host_model.sv ***
`timescale 1ns/1ns
module hrp_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] data_out,
  input  wire logic        st_oe_n,
  input  wire logic        dl_oe_n,
  output      logic        address_strobe_n,
  output      logic [6:0]  addr,
  output      logic        rd_req,
  output      logic        wr_req,
  output      logic [15:0] data_in,
  output      wire         st_line_n,
  output      wire         dl_line_n
);
  // pull-up wins when nobody sinks the line
  assign st_line_n = st_oe_n ? 1'b1 : 1'b0;
  assign dl_line_n = dl_oe_n ? 1'b1 : 1'b0;
  initial begin
    address_strobe_n = 1'b1;
    addr = 7'h00;
    rd_req = 1'b0;
    wr_req = 1'b0;
    data_in = 16'h0000;
  end
  // one clocked write, address under strobe
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    address_strobe_n <= 1'b0;
    addr <= a;
    data_in <= d;
    wr_req <= 1'b1;
    @(posedge ref_clk);
    address_strobe_n <= 1'b1;
    wr_req <= 1'b0;
    data_in <= ~d;
    @(posedge ref_clk);
  endtask
  // callers read lane 0 before lane 1
  task automatic rd(input logic [6:0] a, input logic lane, output logic [15:0] q);
    address_strobe_n <= 1'b0;
    addr <= a;
    data_in <= {lane, 15'h0000};
    rd_req <= 1'b1;
    @(posedge ref_clk);
    address_strobe_n <= 1'b1;
    rd_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 q = data_out;
    @(posedge ref_clk);
  endtask
endmodule // hrp_host_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        bus_width_select = 1'b0;
  logic        rx_clk_active = 1'b1;
  logic [7:0]  stat_event = 8'h00;
  logic        fe_event = 1'b0;
  logic        tick = 1'b0;
  logic [2:0]  hdlc_event = 3'h0;
  logic [6:0]  addr;
  logic        rd_req, wr_req, strobe_n, data_oe_n, bus_busy;
  logic [15:0] data_in, data_out, q;
  logic        st_o, st_oe_n, dl_o, dl_oe_n;
  wire         st_line, dl_line;
  int          err_total = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #50 ref_clk = ~ref_clk;
  hrp_host_port DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .bus_width_select(bus_width_select), .address_strobe_n(strobe_n), .addr(addr),
    .rd_req(rd_req), .wr_req(wr_req), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .bus_busy(bus_busy), .rx_clk_active(rx_clk_active),
    .stat_event(stat_event), .count_tick(tick), .far_end_alarm_channel_event(fe_event),
    .hdlc_event(hdlc_event), .status_irq_n_i(st_line), .status_irq_n_o(st_o),
    .status_irq_oe_n(st_oe_n), .datalink_irq_n_i(dl_line), .datalink_irq_n_o(dl_o),
    .datalink_irq_oe_n(dl_oe_n));
  hrp_host_model host (.ref_clk(ref_clk), .data_out(data_out), .st_oe_n(st_oe_n),
    .dl_oe_n(dl_oe_n), .address_strobe_n(strobe_n), .addr(addr), .rd_req(rd_req),
    .wr_req(wr_req), .data_in(data_in), .st_line_n(st_line), .dl_line_n(dl_line));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [7:0] v);
    stat_event <= v;
    @(posedge ref_clk);
    stat_event <= 8'h00;
    @(posedge ref_clk);
  endtask
  task automatic t_regs;
    host.rd(7'h02, 1'b0, q);
    chk({15'h0000, q[9]}, 16'h0001);
    host.wr(7'h02, 16'h0155);
    host.wr(7'h05, 16'ha55a);
    host.rd(7'h05, 1'b0, q);
    chk(q, 16'ha55a);
    // an alias of 0x05 must not land
    host.wr(7'h45, 16'hffff);
    host.wr(7'h14, 16'h1234);
    host.rd(7'h05, 1'b0, q);
    chk(q, 16'ha55a);
    host.rd(7'h14, 1'b0, q);
    chk(q, 16'h0000);
    // three ticks, then run the counter up to its overflow
    tick <= 1'b1;
    repeat (3) @(posedge ref_clk);
    tick <= 1'b0;
    host.rd(7'h14, 1'b0, q);
    chk(q, 16'h0003);
    host.wr(7'h10, 16'h0100);
    tick <= 1'b1;
    repeat (65533) @(posedge ref_clk);
    tick <= 1'b0;
    @(posedge ref_clk);
    #1 chk({15'h0000, st_line}, 16'h0000);
    @(posedge ref_clk);
    host.rd(7'h11, 1'b0, q);
    chk(q, 16'h0100);
    host.rd(7'h14, 1'b0, q);
    chk(q, 16'h0000);
  endtask
  task automatic t_irq;
    host.wr(7'h10, 16'h0010);
    rx_clk_active <= 1'b0;
    repeat (5) @(posedge ref_clk);
    pulse(8'h01);
    rx_clk_active <= 1'b1;
    repeat (5) @(posedge ref_clk);
    pulse(8'h02);
    #1 chk({15'h0000, st_line}, 16'h0001);
    @(posedge ref_clk);
    pulse(8'h10);
    #1 chk({15'h0000, st_line}, 16'h0000);
    repeat (5) @(posedge ref_clk);
    #1 chk({15'h0000, st_line}, 16'h0000);
    @(posedge ref_clk);
    host.rd(7'h11, 1'b0, q);
    chk(q, 16'h0012);
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0000, st_line}, 16'h0001);
    @(posedge ref_clk);
  endtask
  task automatic t_dl;
    host.wr(7'h12, 16'h0001);
    fe_event <= 1'b1;
    hdlc_event <= 3'h1;
    @(posedge ref_clk);
    fe_event <= 1'b0;
    hdlc_event <= 3'h0;
    @(posedge ref_clk);
    #1 chk({14'h0000, dl_line, st_line}, 16'h0001);
    @(posedge ref_clk);
    host.rd(7'h13, 1'b0, q);
    chk(q, 16'h0003);
  endtask
  task automatic t_byte;
    bus_width_select <= 1'b1;
    repeat (6) @(posedge ref_clk);
    host.wr(7'h05, 16'h0033);
    host.rd(7'h05, 1'b0, q);
    chk(q, 16'h0033);
    host.rd(7'h05, 1'b1, q);
    chk(q, 16'h00a5);
    host.wr(7'h05, 16'h80c4);
    host.rd(7'h05, 1'b0, q);
    chk(q, 16'h0033);
    host.rd(7'h05, 1'b1, q);
    chk(q, 16'h00c4);
    bus_width_select <= 1'b0;
    repeat (6) @(posedge ref_clk);
    host.rd(7'h05, 1'b0, q);
    chk(q, 16'hc433);
  endtask
  task automatic t_reset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    host.rd(7'h05, 1'b0, q);
    chk(q, 16'hc433);
    host.rd(7'h02, 1'b0, q);
    chk(q, 16'h0355);
    host.rd(7'h15, 1'b0, q);
    chk(q, 16'h000e);
  endtask
  task automatic complete_run;
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 70000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_irq;
    t_dl;
    t_byte;
    t_reset;
    complete_run;
  end
endmodule // testbench
